// File: core/rf_conv_consts.vh
// Purpose: constants for the resistance-to-frequency converter control block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: offsets below are byte addresses
`ifndef RF_CONV_CONSTS_VH
`define RF_CONV_CONSTS_VH
`define OFS_CLK_CTL 4'h0
`define OFS_CTL 4'h4
`define OFS_TRG 4'h8
`define OFS_IRQ_FLAG 4'hc
`define OFS_IRQ_EN 4'h0
`define OFS_IRQ_EN_HI 1'b1
`define BIT_DEBUG_RUN 8
`define BIT_MON 8
`define BIT_CONT 7
`define BIT_EVT 6
`define BIT_EN 0
`define FLD_HI 5
`define FLD_LO 4
`define CLOCK_SOURCE_SEL_HI 1
`define CLOCK_SOURCE_SEL_LO 0
`define SRC_INTERNAL_OSC 2'h0
`define SRC_LOSC 2'h1
`define SRC_HOSC 2'h2
`define SRC_EXT 2'h3
`define MODE_DC 2'h0
`define MODE_AC 2'h1
`define RST_CLK_CTL 9'h100
`define NFLAGS 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: core/rf_conv_ctrl.v
// Purpose: register, flag, irq and clock control of one converter channel
// Assumes: oscillator clocks are level-like tick inputs sampled on clk
// Notes: counting engine lives outside; it reports end events as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "rf_conv_consts.vh"
module rf_conv_ctrl #(
	parameter [3:0] SRC_PRESENT = 4'hf
) (
	input wire clk,
	input wire rst_n,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ref_end_meas_ovf,
	input wire ref_end_tb_ovf,
	input wire sens_end_tb_zero,
	input wire sens_end_meas_ovf,
	input wire debug_mode,
	input wire internal_osc,
	input wire low_speed_osc,
	input wire high_speed_osc,
	input wire external_clock_in,
	input wire converter_input_pin,
	input wire osc_clock,
	output reg op_clock_tick,
	output reg monitor_clock_out,
	output reg ref_osc_run,
	output reg sensor_a_run,
	output reg sensor_b_run,
	output wire auto_stop_en,
	output wire event_mode,
	output wire [1:0] osc_mode_sel,
	output wire channel_enable,
	output wire irq
);
	// ======================================================
	// registers
	reg debug_run;
	reg [1:0] clock_divider_sel;
	reg [1:0] clock_source_sel;
	reg monitor_half_rate;
	reg continuous_osc;
	reg event_r;
	reg [1:0] mode_r;
	reg enable_r;
	reg [4:0] irq_flag_register;
	reg [4:0] irq_enable_register;
	reg [4:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	wire [4:0] set_evt;
	wire do_write;
	wire [3:0] wofs;
	wire [3:0] rofs;
	reg [31:0] next_rdata;
	reg next_rerr;
	assign event_mode = event_r;
	assign osc_mode_sel = mode_r;
	assign channel_enable = enable_r;
	assign auto_stop_en = ~continuous_osc;
	assign irq = |(irq_flag_register & irq_enable_register);
	// ======================================================
	// write path: address and data accepted in either order
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign wofs = aw_addr[3:0];
	always @(posedge clk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ======================================================
	// register writes
	wire wr_ok = do_write && (aw_addr[1:0] == 2'h0);
	wire wr_lo = wr_ok && (aw_addr[4] == 1'b0);
	wire wr_en = wr_ok && (aw_addr[4] == `OFS_IRQ_EN_HI) && (wofs == `OFS_IRQ_EN);
	wire wr_clk = wr_lo && (wofs == `OFS_CLK_CTL) && !enable_r;
	wire wr_ctl = wr_lo && (wofs == `OFS_CTL);
	wire wr_trg = wr_lo && (wofs == `OFS_TRG);
	wire wr_flag = wr_lo && (wofs == `OFS_IRQ_FLAG) && w_strb[0];
	wire [1:0] req_src = w_data[`CLOCK_SOURCE_SEL_HI:`CLOCK_SOURCE_SEL_LO];
	// reset word kept whole so debug_run takes exactly its own bit
	wire [8:0] rst_clk_ctl = `RST_CLK_CTL;
	always @(posedge clk) begin
		if (!rst_n) begin
			debug_run <= rst_clk_ctl[`BIT_DEBUG_RUN];
			clock_divider_sel <= 2'h0;
			clock_source_sel <= `SRC_INTERNAL_OSC;
			monitor_half_rate <= 1'b0;
			continuous_osc <= 1'b0;
			event_r <= 1'b0;
			mode_r <= `MODE_DC;
			enable_r <= 1'b0;
			irq_enable_register <= 5'h00;
		end else begin
			if (wr_clk) begin
				if (w_strb[1])
					debug_run <= w_data[`BIT_DEBUG_RUN];
				if (w_strb[0]) begin
					clock_divider_sel <= w_data[`FLD_HI:`FLD_LO];
					// a source this chip lacks leaves the old source in place
					if (SRC_PRESENT[req_src])
						clock_source_sel <= req_src;
				end
			end
			if (wr_ctl) begin
				if (w_strb[1])
					monitor_half_rate <= w_data[`BIT_MON];
				if (w_strb[0]) begin
					continuous_osc <= w_data[`BIT_CONT];
					event_r <= w_data[`BIT_EVT];
					mode_r <= w_data[`FLD_HI:`FLD_LO];
					enable_r <= w_data[`BIT_EN];
				end
			end
			if (wr_en && w_strb[0])
				irq_enable_register <= w_data[`NFLAGS-1:0];
		end
	end
	// ======================================================
	// oscillation triggers; engine end events clear the run bits unless continuous_osc is set
	wire any_end = ref_end_meas_ovf | ref_end_tb_ovf | sens_end_tb_zero | sens_end_meas_ovf;
	wire auto_end = any_end & ~continuous_osc;
	// drop the run bits on the very write that clears enable, so that no
	// run bit outlives the enable by a cycle
	wire dis_now = wr_ctl && w_strb[0] && !w_data[`BIT_EN];
	always @(posedge clk) begin
		if (!rst_n || !enable_r || dis_now) begin
			ref_osc_run <= 1'b0;
			sensor_a_run <= 1'b0;
			sensor_b_run <= 1'b0;
		end else if (wr_trg && w_strb[0]) begin
			ref_osc_run <= w_data[0];
			sensor_a_run <= w_data[1];
			sensor_b_run <= w_data[2] && (mode_r != `MODE_AC);
		end else if (auto_end) begin
			ref_osc_run <= 1'b0;
			sensor_a_run <= 1'b0;
			sensor_b_run <= 1'b0;
		end
	end
	// ======================================================
	// interrupt flags; a set event wins over a write-1 clear
	assign set_evt[0] = ref_osc_run & ref_end_meas_ovf & ~continuous_osc;
	assign set_evt[1] = sensor_a_run & sens_end_tb_zero & ~continuous_osc;
	assign set_evt[2] = sensor_b_run & sens_end_tb_zero & ~continuous_osc;
	assign set_evt[3] = (sensor_a_run | sensor_b_run) & sens_end_meas_ovf & ~continuous_osc;
	assign set_evt[4] = ref_osc_run & ref_end_tb_ovf & ~continuous_osc;
	always @(posedge clk) begin
		if (!rst_n)
			irq_flag_register <= 5'h00;
		else
			irq_flag_register <= (irq_flag_register &
				~(wr_flag ? w_data[`NFLAGS-1:0] : 5'h00)) | set_evt;
	end
	// ======================================================
	// read path
	assign s_axi_arready = ~s_axi_rvalid;
	assign rofs = s_axi_araddr[3:0];
	always @* begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		if (s_axi_araddr[1:0] != 2'h0)
			next_rerr = 1'b1;
		else if (s_axi_araddr[4] == `OFS_IRQ_EN_HI) begin
			if (rofs == `OFS_IRQ_EN)
				next_rdata = {27'h0, irq_enable_register};
			else
				next_rerr = 1'b1;
		end else begin
			case (rofs)
			`OFS_CLK_CTL: next_rdata = {23'h0, debug_run, 2'h0, clock_divider_sel, 2'h0,
				clock_source_sel};
			`OFS_CTL: next_rdata = {23'h0, monitor_half_rate, continuous_osc, event_r, mode_r,
				3'h0, enable_r};
			`OFS_TRG: next_rdata = {29'h0, sensor_b_run, sensor_a_run, ref_osc_run};
			`OFS_IRQ_FLAG: next_rdata = {27'h0, irq_flag_register};
			default: next_rerr = 1'b1;
			endcase
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// ======================================================
	// clock selection and division; pins pass two flops first
	reg [3:0] src_s1;
	reg [3:0] src_s2;
	reg [3:0] src_s3;
	reg [1:0] osc_s;
	reg osc_prev;
	reg pin_s1;
	reg pin_s2;
	reg [2:0] div_cnt;
	reg [2:0] mon_cnt;
	reg sel_lvl;
	reg sel_edge;
	reg divided;
	always @* begin
		sel_lvl = src_s2[clock_source_sel];
		if (clock_source_sel == `SRC_EXT && event_r)
			sel_lvl = pin_s2;
		sel_edge = sel_lvl & ~src_s3[clock_source_sel];
		if (clock_source_sel == `SRC_EXT && event_r)
			sel_edge = pin_s2 & ~src_s3[`SRC_EXT];
		case (clock_divider_sel)
		2'h0: divided = 1'b1;
		2'h1: divided = div_cnt[0] == 1'b0;
		2'h2: divided = div_cnt[1:0] == 2'h0;
		default: divided = div_cnt == 3'h0;
		endcase
		if (clock_source_sel == `SRC_LOSC || clock_source_sel == `SRC_EXT)
			divided = 1'b1;
	end
	wire clk_gate = enable_r && (debug_run || !debug_mode);
	always @(posedge clk) begin
		if (!rst_n) begin
			src_s1 <= 4'h0;
			src_s2 <= 4'h0;
			src_s3 <= 4'h0;
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			osc_s <= 2'h0;
			osc_prev <= 1'b0;
			div_cnt <= 3'h0;
			mon_cnt <= 3'h0;
			op_clock_tick <= 1'b0;
			monitor_clock_out <= 1'b0;
		end else begin
			src_s1 <= {external_clock_in, high_speed_osc, low_speed_osc, internal_osc};
			src_s2 <= src_s1;
			src_s3 <= {(event_r && clock_source_sel == `SRC_EXT) ? pin_s2 : src_s2[3],
				src_s2[2:0]};
			pin_s1 <= converter_input_pin;
			pin_s2 <= pin_s1;
			osc_s <= {osc_s[0], osc_clock};
			osc_prev <= osc_s[1];
			op_clock_tick <= 1'b0;
			if (!clk_gate)
				div_cnt <= 3'h0;
			else if (sel_edge) begin
				div_cnt <= div_cnt + 3'h1;
				op_clock_tick <= divided;
			end
			// half rate toggles on each oscillation rising edge
			if (osc_s[1] && !osc_prev)
				mon_cnt <= mon_cnt + 3'h1;
			monitor_clock_out <= monitor_half_rate ? mon_cnt[0] : osc_s[1];
		end
	end
endmodule // rf_conv_ctrl
`default_nettype wire

// File: tb/rf_engine_model.sv
// Purpose: counting engine and oscillator stand-in for the converter control
// Assumes: end events are one-cycle pulses on clk
// Notes: end pulse follows a go request by a fixed four cycles
`timescale 1ns/1ps
`default_nettype none
module rf_engine_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] kind,
	input wire logic running,
	input wire logic event_mode,
	output logic [3:0] ends = 4'h0,
	output logic osc_clock = 1'b0,
	output logic converter_input_pin
);
	logic [2:0] dly = 3'h0;
	// ==========
	// engine
	always @(posedge clk) begin
		dly <= {dly[1:0], go};
		ends <= dly[2] ? 4'h1 << kind : 4'h0;
		// oscillator stands still low outside oscillation
		osc_clock <= running & ~osc_clock;
	end
	// pin rests at its pull-down until event mode is chosen
	assign converter_input_pin = event_mode & osc_clock;
endmodule // rf_engine_model
`default_nettype wire

// File: tb/rf_conv_ctrl_asserts.sv
// Purpose: port-level temporal checks of the converter control
// Assumes: sync active-low reset, end events one cycle wide
// Notes: flag and enable registers are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module rf_conv_ctrl_asserts (
	input wire clk,
	input wire rst_n,
	input wire s_axi_bvalid,
	input wire ref_end_meas_ovf,
	input wire ref_end_tb_ovf,
	input wire sens_end_tb_zero,
	input wire sens_end_meas_ovf,
	input wire op_clock_tick,
	input wire ref_osc_run,
	input wire sensor_a_run,
	input wire sensor_b_run,
	input wire auto_stop_en,
	input wire event_mode,
	input wire [1:0] osc_mode_sel,
	input wire channel_enable,
	input wire irq
);
	// ==========
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire sens_run = sensor_a_run | sensor_b_run;
	wire sens_end = sens_end_tb_zero | sens_end_meas_ovf;
	wire any_end = ref_end_meas_ovf | ref_end_tb_ovf | sens_end;
	sequence s_ref_end;
		ref_osc_run && (ref_end_meas_ovf || ref_end_tb_ovf);
	endsequence
	sequence s_off2;
		!channel_enable ##1 !channel_enable;
	endsequence
	a_run_needs_en: assert property ((ref_osc_run | sens_run) |-> channel_enable)
		else $error("run bit while disabled");
	a_ac_no_b: assert property ($rose(sensor_b_run) |-> osc_mode_sel != 2'h1)
		else $error("sensor b started in ac mode");
	a_ref_stop: assert property (auto_stop_en ##0 s_ref_end |=> !ref_osc_run)
		else $error("reference run kept after end");
	a_cont_keeps: assert property (!auto_stop_en ##0 s_ref_end |=> ref_osc_run)
		else $error("continuous run stopped");
	a_sens_stop: assert property (sens_run && auto_stop_en && sens_end |=> !sens_run)
		else $error("sensor run kept after end");
	a_tick_off: assert property (s_off2 |-> !op_clock_tick)
		else $error("tick while disabled");
	a_irq_cause: assert property ($rose(irq) |-> $past(any_end) || $rose(s_axi_bvalid))
		else $error("irq rose without cause");
	a_ctl_stable: assert property (!$rose(s_axi_bvalid) |->
		$stable({event_mode, osc_mode_sel, auto_stop_en, channel_enable}))
		else $error("control changed without write");
endmodule // rf_conv_ctrl_asserts
bind rf_conv_ctrl rf_conv_ctrl_asserts chk_i (.*);
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: AXI4-Lite master, engine model on the far side
// Notes: write strobes are held constant; tick and monitor edges are counted at negedge
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rst_n = 0, debug_mode = 0, go = 0, mon_prev = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rd_val;
	logic [3:0] s_axi_wstrb = 4'hf, cnt = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [1:0] kind = 0, rsp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, osc_mode_sel;
	wire [31:0] s_axi_rdata;
	wire ref_end_meas_ovf, ref_end_tb_ovf, sens_end_tb_zero, sens_end_meas_ovf;
	wire op_clock_tick, monitor_clock_out, ref_osc_run, sensor_a_run, sensor_b_run;
	wire auto_stop_en, event_mode, channel_enable, irq, osc_clock, converter_input_pin;
	wire internal_osc = cnt[1], low_speed_osc = cnt[3];
	wire high_speed_osc = cnt[0], external_clock_in = cnt[2];
	int err_count = 0, checks = 0, cyc = 0, ticks = 0, mon_rises = 0;
	localparam logic [2:0] TRG [5] = '{3'h1, 3'h2, 3'h4, 3'h2, 3'h1};
	localparam logic [1:0] EVK [5] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
	// high-speed oscillator left out so that an absent source can be tried
	rf_conv_ctrl #(.SRC_PRESENT(4'hb)) uut (.*);
	rf_engine_model eng (.clk(clk), .go(go), .kind(kind), .event_mode(event_mode),
		.running(ref_osc_run | sensor_a_run | sensor_b_run), .osc_clock(osc_clock),
		.ends({sens_end_meas_ovf, sens_end_tb_zero, ref_end_tb_ovf, ref_end_meas_ovf}),
		.converter_input_pin(converter_input_pin));
	initial forever #5 clk = ~clk;
	// ==========
	// helpers
	always @(negedge clk) begin
		ticks <= ticks + op_clock_tick;
		mon_prev <= monitor_clock_out;
		mon_rises <= mon_rises + (monitor_clock_out & ~mon_prev);
	end
	always @(posedge clk) begin
		cnt <= cnt + 4'h1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim;
		end
	end
	task end_sim;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input [4:0] a, input [31:0] d);
		logic aw, w;
		aw = 1;
		w = 1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (aw || w) begin
			@(posedge clk);
			aw = aw & ~s_axi_awready;
			w = w & ~s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input [4:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		rd_val = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task rc(input string n, input [4:0] a, input [31:0] e);
		rd(a);
		chk(n, e, rd_val);
	endtask
	task pulse(input [1:0] k);
		@(posedge clk);
		kind <= k;
		go <= 1;
		@(posedge clk);
		go <= 0;
		repeat (6) @(posedge clk);
	endtask
	// ==========
	// scenarios
	task t_reset;
		rc("clk_ctl", 5'h00, 32'h100);
		rc("ctl", 5'h04, 32'h0);
		rc("flags", 5'h0c, 32'h0);
		rc("irq_en", 5'h10, 32'h0);
		rd(5'h14);
		chk("unmapped_resp", 32'h2, rsp);
		$display("test reset done");
	endtask
	task t_flags;
		logic [4:0] f;
		wr(5'h04, 32'h1);
		for (int i = 0; i < 5; i++) begin
			f = 5'h1 << i;
			wr(5'h10, i[0] ? f : ~f);
			wr(5'h08, TRG[i]);
			pulse(EVK[i]);
			rc("flag_set", 5'h0c, f);
			chk("irq_mask", i[0], irq);
			rc("run_stop", 5'h08, 32'h0);
			wr(5'h0c, f);
			rc("flag_clr", 5'h0c, 32'h0);
			chk("irq_clr", 0, irq);
		end
		$display("test flags done");
	endtask
	task t_lock;
		wr(5'h00, 32'h31);
		rc("clk_locked", 5'h00, 32'h100);
		wr(5'h04, 32'h0);
		chk("enable_off", 0, channel_enable);
		wr(5'h00, 32'h31);
		rc("clk_free", 5'h00, 32'h31);
		wr(5'h08, 32'h1);
		rc("trg_off", 5'h08, 32'h0);
		wr(5'h00, 32'h100);
		$display("test lock done");
	endtask
	task t_ac;
		wr(5'h04, 32'h11);
		chk("mode", 1, osc_mode_sel);
		wr(5'h08, 32'h4);
		rc("trg_b_ac", 5'h08, 32'h0);
		wr(5'h08, 32'h2);
		rc("trg_a_ac", 5'h08, 32'h2);
		wr(5'h08, 32'h0);
		$display("test ac done");
	endtask
	task t_cont;
		int t0, m0;
		wr(5'h04, 32'hc1);
		chk("auto_stop", 0, auto_stop_en);
		chk("event", 1, event_mode);
		t0 = ticks;
		repeat (20) @(posedge clk);
		chk("ticks_on", 1, (ticks - t0) inside {[4:6]});
		wr(5'h08, 32'h1);
		pulse(2'h0);
		rc("cont_run", 5'h08, 32'h1);
		rc("cont_flag", 5'h0c, 32'h0);
		m0 = mon_rises;
		repeat (40) @(posedge clk);
		chk("mon_full", 1, (mon_rises - m0) inside {[19:21]});
		wr(5'h04, 32'h1c1);
		m0 = mon_rises;
		repeat (40) @(posedge clk);
		chk("mon_half", 1, (mon_rises - m0) inside {[9:11]});
		wr(5'h04, 32'h0);
		rc("run_cleared", 5'h08, 32'h0);
		t0 = ticks;
		repeat (20) @(posedge clk);
		chk("ticks_off", 0, ticks - t0);
		$display("test cont done");
	endtask
	task t_clk;
		int t0;
		wr(5'h00, 32'h112);
		rc("src_absent", 5'h00, 32'h110);
		wr(5'h04, 32'h1);
		debug_mode <= 1;
		t0 = ticks;
		repeat (64) @(posedge clk);
		chk("tick_div2_dbg", 1, (ticks - t0) inside {[7:9]});
		wr(5'h04, 32'h0);
		wr(5'h00, 32'h31);
		wr(5'h04, 32'h1);
		t0 = ticks;
		repeat (64) @(posedge clk);
		chk("tick_dbg_stop", 0, ticks - t0);
		debug_mode <= 0;
		t0 = ticks;
		repeat (64) @(posedge clk);
		chk("tick_losc", 1, (ticks - t0) inside {[3:5]});
		wr(5'h04, 32'h0);
		wr(5'h00, 32'h133);
		wr(5'h04, 32'h1);
		t0 = ticks;
		repeat (64) @(posedge clk);
		chk("tick_ext", 1, (ticks - t0) inside {[7:9]});
		wr(5'h04, 32'hc1);
		wr(5'h08, 32'h1);
		t0 = ticks;
		repeat (64) @(posedge clk);
		chk("tick_event", 1, (ticks - t0) inside {[31:33]});
		wr(5'h04, 32'h0);
		$display("test clk done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_flags;
		t_lock;
		t_ac;
		t_cont;
		t_clk;
		end_sim;
	end
endmodule // tb
`default_nettype wire
